//--- design/psc_top.v
// Power-state, voltage-code and lock control for two regulators.
`timescale 1ns/1ps
`include "psc_regs.vh"

module psc_top #(
  parameter TWO_PHASE_B = 1
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       reset,
  // Decoded serial-bus command
  input  wire       cmd_valid,
  input  wire [2:0] cmd_code,
  input  wire       cmd_rail,
  input  wire [7:0] cmd_addr,
  input  wire [7:0] cmd_data,
  // Command answer
  output reg        ack_valid_ff,
  output reg  [1:0] ack_code_ff,
  output reg  [7:0] ack_rdata_ff,
  // Regulator A controls
  output wire       a_phase1_en,
  output wire       a_phase2_en,
  output wire       a_phase3_en,
  output wire       a_skip_en,
  output wire [7:0] a_vid_code,
  // Regulator B controls
  output wire       b_phase1_en,
  output wire       b_phase2_en,
  output wire       b_skip_en,
  output wire [7:0] b_vid_code
);

  wire [1:0]  reject_w;
  wire [15:0] rdata_w;
  wire [5:0]  phase_en_w;
  wire [1:0]  skip_w;
  wire [15:0] vid_w;

  // Each rail keeps its own configuration register, so locking one rail
  // leaves the other free to take voltage and state commands.
  genvar r;
  generate
    for (r = 0; r < 2; r = r + 1) begin : g_rail
      reg  [7:0] vid_ff;
      reg  [7:0] ps_ff;
      reg  [`PSC_CFG_WIDTH-1:0] cfg_ff;
      reg  [7:0] nxt_vid;
      reg  [7:0] nxt_ps;
      reg  [`PSC_CFG_WIDTH-1:0] nxt_cfg;
      reg        rej;
      reg  [7:0] rd;
      wire       sel;
      wire       is_vid;
      wire       is_ps;
      wire       is_dat;
      wire       is_get;
      wire       locked;
      wire       ps_ok;
      wire       rej_lock;
      wire       rej_state;
      wire       rej_addr;
      wire       rej_code;
      reg  [7:0] ps_onehot;

      assign sel    = cmd_valid && (cmd_rail == r);
      assign is_vid = (cmd_code == `PSC_CMD_SETVID_FAST) ||
                      (cmd_code == `PSC_CMD_SETVID_SLOW);
      assign is_ps  = (cmd_code == `PSC_CMD_SET_PS);
      assign is_dat = (cmd_code == `PSC_CMD_SET_REG_DAT);
      assign is_get = (cmd_code == `PSC_CMD_GET_REG);
      assign locked = cfg_ff[`PSC_CFG_LOCK_BIT];
      assign ps_ok  = (cmd_data <= `PSC_PS_MAX_CODE);

      // Refusal reasons stay apart so each one can be probed on its own.
      assign rej_lock  = locked && (is_vid || is_ps);
      assign rej_state = is_ps && !ps_ok;
      assign rej_addr  = is_dat && (cmd_addr != `PSC_MULTI_CFG_ADDR);
      assign rej_code  = !(is_vid || is_ps || is_dat || is_get);

      always @* begin
        rej = 1'b0;
        if (rej_lock) begin
          rej = 1'b1;
        end else if (rej_state) begin
          rej = 1'b1;
        end else if (rej_addr) begin
          rej = 1'b1;
        end else if (rej_code) begin
          rej = 1'b1;
        end
      end

      // Register readback; reserved configuration bits read as zero.
      always @* begin
        rd = `PSC_RDATA_RESET;
        if (cmd_addr == `PSC_VID_REG_ADDR) begin
          rd = vid_ff;
        end else if (cmd_addr == `PSC_POWER_STATE_ADDR) begin
          rd = ps_ff;
        end else if (cmd_addr == `PSC_MULTI_CFG_ADDR) begin
          rd = {{(8-`PSC_CFG_WIDTH){1'b0}}, cfg_ff};
        end
      end

      // Only supported codes map to a stored bit. Codes four to seven are
      // refused before this point, and the default keeps the old state.
      always @* begin
        ps_onehot = ps_ff;
        case (cmd_data[2:0])
          `PSC_CODE_PS0: begin
            ps_onehot = `PSC_PS_FULL;
          end
          `PSC_CODE_PS1: begin
            ps_onehot = `PSC_PS_LOW_CURRENT;
          end
          `PSC_CODE_PS2: begin
            ps_onehot = `PSC_PS_LOW_SLEEP;
          end
          `PSC_CODE_PS3: begin
            ps_onehot = `PSC_PS_ULTRA_SLEEP;
          end
          default: begin
            ps_onehot = ps_ff;
          end
        endcase
      end

      always @* begin
        nxt_vid = vid_ff;
        nxt_ps  = ps_ff;
        nxt_cfg = cfg_ff;
        if (sel && !rej) begin
          if (is_vid && (cmd_data != vid_ff)) begin
            // An output change always returns the rail to full power.
            nxt_vid = cmd_data;
            nxt_ps  = `PSC_PS_FULL;
          end else if (is_ps) begin
            nxt_ps = ps_onehot;
          end else if (is_dat) begin
            // Only this write can clear the lock, so it is never locked.
            nxt_cfg = cmd_data[`PSC_CFG_WIDTH-1:0];
          end
        end
      end

      always @(posedge core_clk or posedge reset) begin
        if (reset) begin
          vid_ff <= `PSC_VID_RESET;
          ps_ff  <= `PSC_PS_RESET;
          cfg_ff <= `PSC_CFG_RESET;
        end else begin
          vid_ff <= nxt_vid;
          ps_ff  <= nxt_ps;
          cfg_ff <= nxt_cfg;
        end
      end

      psc_ps_decode #(
        .NUM_PHASES ((r == 0) ? 3 : ((TWO_PHASE_B != 0) ? 2 : 1))
      ) u_decode (
        .core_clk          (core_clk),
        .reset             (reset),
        .power_state_field (ps_ff),
        .phase_en_ff       (phase_en_w[r*3 +: 3]),
        .skip_en_ff        (skip_w[r])
      );

      assign reject_w[r]       = rej;
      assign rdata_w[r*8 +: 8] = rd;
      assign vid_w[r*8 +: 8]   = vid_ff;
    end
  endgenerate

  reg       rej_sel;
  reg [7:0] rdata_sel;
  reg [1:0] nxt_ack_code;
  reg [7:0] nxt_ack_rdata;

  // Only the addressed rail's verdict and readback reach the answer.
  always @* begin
    if (cmd_rail) begin
      rej_sel   = reject_w[1];
      rdata_sel = rdata_w[15:8];
    end else begin
      rej_sel   = reject_w[0];
      rdata_sel = rdata_w[7:0];
    end
  end

  // Read data is zero on every answer but a read, so a stale value never
  // looks like a fresh one.
  always @* begin
    nxt_ack_code  = `PSC_ACK_DONE;
    nxt_ack_rdata = `PSC_RDATA_RESET;
    if (rej_sel) begin
      nxt_ack_code = `PSC_ACK_REJECT;
    end else if (cmd_code == `PSC_CMD_GET_REG) begin
      nxt_ack_rdata = rdata_sel;
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ack_valid_ff <= 1'b0;
      ack_code_ff  <= `PSC_ACK_RESET;
      ack_rdata_ff <= `PSC_RDATA_RESET;
    end else begin
      ack_valid_ff <= cmd_valid;
      if (cmd_valid) begin
        ack_code_ff  <= nxt_ack_code;
        ack_rdata_ff <= nxt_ack_rdata;
      end
    end
  end

  // Regulator A outputs.
  assign a_phase1_en = phase_en_w[0];
  assign a_phase2_en = phase_en_w[1];
  assign a_phase3_en = phase_en_w[2];
  assign a_skip_en   = skip_w[0];
  assign a_vid_code  = vid_w[7:0];

  // Regulator B outputs. The second rail has no third phase, so the top
  // slot of its decoder stays unused.
  assign b_phase1_en = phase_en_w[3];
  assign b_phase2_en = phase_en_w[4];
  assign b_skip_en   = skip_w[1];
  assign b_vid_code  = vid_w[15:8];

endmodule // psc_top

//--- design/psc_regs.vh
// Register offsets, field positions, command and answer codes.
// Summary of operation
// - A set-power-state command adopts the state and stores it for readback.
// - State zero enables phases one to three, pulse skipping off.
// - State one enables phase one only, pulse skipping off.
// - State two enables phase one only, pulse skipping on.
// - State three behaves like state two.
// - Codes four to seven are never decoded into any configuration.
// - An unsupported state is answered with the rejected code; state kept.
// - Voltage code and power state are stored independently.
// - A voltage command that changes the output forces state zero.
// - Both regulators use the same state decoding.
// - Second regulator drives phase one, and phase two on two-phase variant or from reset until the first clock.
// - While the lock bit is set, voltage and state commands are rejected.
// - The power-state register is eight bits, one bit per state.
`ifndef PSC_REGS_VH
`define PSC_REGS_VH

// Register offsets.
`define PSC_VID_REG_ADDR      8'h31
`define PSC_POWER_STATE_ADDR  8'h32
`define PSC_MULTI_CFG_ADDR    8'h34

// Field positions in the multi-regulator configuration register.
`define PSC_CFG_POK_BIT       0
`define PSC_CFG_LOCK_BIT      1
`define PSC_CFG_WIDTH         2

// Reset values.
`define PSC_VID_RESET         8'h00
`define PSC_PS_RESET          8'h01
`define PSC_CFG_RESET         2'h0

// Highest supported power-state code.
`define PSC_PS_MAX_CODE       8'h03
`define PSC_PS_FULL           8'h01
`define PSC_PS_LOW_CURRENT    8'h02
`define PSC_PS_LOW_SLEEP      8'h04
`define PSC_PS_ULTRA_SLEEP    8'h08

// Command codes on the decoded command port.
`define PSC_CMD_SETVID_FAST   3'h1
`define PSC_CMD_SETVID_SLOW   3'h2
`define PSC_CMD_SET_PS        3'h4
`define PSC_CMD_SET_REG_DAT   3'h5
`define PSC_CMD_GET_REG       3'h7

// Answer codes.
`define PSC_ACK_DONE          2'h2
`define PSC_ACK_REJECT        2'h3

// State codes carried by a set-power-state command.
`define PSC_CODE_PS0          3'h0
`define PSC_CODE_PS1          3'h1
`define PSC_CODE_PS2          3'h2
`define PSC_CODE_PS3          3'h3

// Phase-enable patterns and answer register reset values.
`define PSC_PHASES_ALL        3'h7
`define PSC_PHASES_ONE        3'h1
`define PSC_ACK_RESET         2'h0
`define PSC_RDATA_RESET       8'h00

`endif

//--- design/psc_ps_decode.v
// Power-state to phase-enable and pulse-skip decoder for one regulator.
`timescale 1ns/1ps
`include "psc_regs.vh"

module psc_ps_decode #(
  parameter NUM_PHASES = 3
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       reset,
  // Stored one-hot power state
  input  wire [7:0] power_state_field,
  // Regulator controls
  output reg  [2:0] phase_en_ff,
  output reg        skip_en_ff
);

  reg [2:0] nxt_phase_en;
  reg       nxt_skip_en;
  wire [2:0] fitted_mask;

  // Phases beyond what this regulator drives stay off in every state; only reset turns all three on, unmasked.
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_mask
      assign fitted_mask[i] = (i < NUM_PHASES) ? 1'b1 : 1'b0;
    end
  endgenerate

  always @* begin
    // Unused codes cannot be stored, but fall back to full power anyway.
    nxt_phase_en = `PSC_PHASES_ALL;
    nxt_skip_en  = 1'b0;
    case (power_state_field)
      `PSC_PS_FULL: begin
        nxt_phase_en = `PSC_PHASES_ALL;
        nxt_skip_en  = 1'b0;
      end
      `PSC_PS_LOW_CURRENT: begin
        nxt_phase_en = `PSC_PHASES_ONE;
        nxt_skip_en  = 1'b0;
      end
      `PSC_PS_LOW_SLEEP: begin
        nxt_phase_en = `PSC_PHASES_ONE;
        nxt_skip_en  = 1'b1;
      end
      `PSC_PS_ULTRA_SLEEP: begin
        nxt_phase_en = `PSC_PHASES_ONE;
        nxt_skip_en  = 1'b1;
      end
      default: begin
        nxt_phase_en = `PSC_PHASES_ALL;
        nxt_skip_en  = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phase_en_ff <= `PSC_PHASES_ALL;
      skip_en_ff  <= 1'b0;
    end else begin
      phase_en_ff <= nxt_phase_en & fitted_mask;
      skip_en_ff  <= nxt_skip_en;
    end
  end

endmodule // psc_ps_decode

//--- tb/psc_top_properties.sv
// Concurrent checks on the power-state block ports.
`timescale 1ns/1ps
module psc_top_properties (
  // Clock, reset and command
  input wire       core_clk,
  input wire       reset,
  input wire       cmd_valid,
  input wire [2:0] cmd_code,
  input wire       cmd_rail,
  input wire [7:0] cmd_data,
  // Answer and regulator controls
  input wire       ack_valid_ff,
  input wire [1:0] ack_code_ff,
  input wire       a_phase1_en,
  input wire       a_phase2_en,
  input wire       a_phase3_en,
  input wire       a_skip_en,
  input wire [7:0] a_vid_code,
  input wire       b_phase2_en,
  input wire       b_skip_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire [3:0] a_ph = {a_phase1_en, a_phase2_en, a_phase3_en, a_skip_en};
  // Outputs land one edge after the answer that accepted the state.
  property ps_out(d, o);
    (cmd_valid && cmd_code == 3'h4 && !cmd_rail && cmd_data == d)
      ##1 ack_code_ff == 2'h2 |=> o;
  endproperty
  AST_ACK: assert property (cmd_valid |=> ack_valid_ff)
    else $error("no answer to command");
  AST_BAD_PS: assert property (
    cmd_valid && cmd_code == 3'h4 && cmd_data > 8'h03
      |=> ack_valid_ff && ack_code_ff == 2'h3) else $error("bad state taken");
  AST_PS0: assert property (ps_out(8'h00, a_ph == 4'hE))
    else $error("state zero decode");
  AST_PS1: assert property (ps_out(8'h01, a_ph == 4'h8))
    else $error("state one decode");
  AST_PS2: assert property (ps_out(8'h02, a_ph == 4'h9))
    else $error("state two decode");
  AST_VID: assert property (
    (cmd_valid && cmd_code == 3'h1 && !cmd_rail)
    ##1 ack_code_ff == 2'h2 |-> a_vid_code == $past(cmd_data))
    else $error("voltage not stored");
  AST_VID_FULL: assert property ((
    cmd_valid && cmd_code == 3'h2 && !cmd_rail && cmd_data != a_vid_code)
    ##1 ack_code_ff == 2'h2 |=> a_ph == 4'hE) else $error("no full power");
  AST_B_PH2: assert property (b_skip_en |-> !b_phase2_en)
    else $error("second phase on while skipping");
  cover property (ack_valid_ff && ack_code_ff == 2'h3);
  cover property (a_skip_en);
  cover property (cmd_valid && cmd_code == 3'h5);
endmodule // psc_top_properties
bind psc_top psc_top_properties i_props (.core_clk, .reset, .cmd_valid,
  .cmd_code, .cmd_rail, .cmd_data, .ack_valid_ff, .ack_code_ff,
  .a_phase1_en, .a_phase2_en, .a_phase3_en, .a_skip_en, .a_vid_code,
  .b_phase2_en, .b_skip_en);

//--- tb/psc_cpu_model.sv
// Bus-master model that issues decoded commands to the block.
`timescale 1ns/1ps
module psc_cpu_model (
  // Clock
  input  wire        core_clk,
  // Command
  output logic       cmd_valid = 1'b0,
  output logic [2:0] cmd_code = 3'h0,
  output logic       cmd_rail = 1'b0,
  output logic [7:0] cmd_addr = 8'h00,
  output logic [7:0] cmd_data = 8'h00
);
  // Idle fields are inverted so nothing can lean on a stale value.
  task send(input [2:0] c, input r, input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    #1;
    {cmd_valid, cmd_code, cmd_rail} = {1'b1, c, r};
    {cmd_addr, cmd_data} = {a, d};
    @(posedge core_clk);
    #1;
    {cmd_valid, cmd_code, cmd_rail} = {1'b0, ~c, ~r};
    {cmd_addr, cmd_data} = {~a, ~d};
  endtask
endmodule // psc_cpu_model

//--- tb/power_state_phase_control_test.sv
// Self-checking bench for the power-state and phase control block.
`timescale 1ns/1ps
module power_state_phase_control_test;
  logic core_clk = 0;
  logic reset = 1;
  wire cmd_valid, cmd_rail, ack_valid_ff, a_phase1_en, a_phase2_en;
  wire a_phase3_en, a_skip_en, b_phase1_en, b_phase2_en, b_skip_en;
  wire [2:0] cmd_code;
  wire [1:0] ack_code_ff;
  wire [7:0] cmd_addr, cmd_data, ack_rdata_ff, a_vid_code, b_vid_code;
  int fails = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h32DE745A;
  logic [7:0] st [2];
  logic [7:0] vid [2];
  logic r;
  logic [7:0] d;
  always #5 core_clk = ~core_clk;
  psc_cpu_model m (.core_clk, .cmd_valid, .cmd_code, .cmd_rail, .cmd_addr,
    .cmd_data);
  psc_top i_dut (.core_clk, .reset, .cmd_valid, .cmd_code, .cmd_rail,
    .cmd_addr, .cmd_data, .ack_valid_ff, .ack_code_ff, .ack_rdata_ff,
    .a_phase1_en, .a_phase2_en, .a_phase3_en, .a_skip_en, .a_vid_code,
    .b_phase1_en, .b_phase2_en, .b_skip_en, .b_vid_code);
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected {phase1, phase2, phase3, skip} for a one-hot state.
  function logic [3:0] dec(input logic [7:0] s);
    return s == 8'h01 ? 4'hE : s == 8'h02 ? 4'h8 : 4'h9;
  endfunction
  // Regulator B has no third phase, so its second phase fills that slot.
  function logic [3:0] ph(input logic x);
    return x ? {b_phase1_en, b_phase2_en, b_phase2_en, b_skip_en}
             : {a_phase1_en, a_phase2_en, a_phase3_en, a_skip_en};
  endfunction
  task chk(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (e !== g) begin
      fails++;
      $display("CHECK FAILED at %0t: exp %0h got %0h", $time, e, g);
    end
  endtask
  task cmd(input [2:0] c, input x, input [7:0] a, input [7:0] v,
           input [1:0] e);
    m.send(c, x, a, v);
    chk({7'h00, 1'b1}, {7'h00, ack_valid_ff});
    chk({6'h00, e}, {6'h00, ack_code_ff});
    @(posedge core_clk);
    #1;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    end_sim;
  end
  initial begin
    st = '{8'h01, 8'h01};
    vid = '{8'h00, 8'h00};
    repeat (8) @(posedge core_clk);
    #1 reset = 0;
    chk(dec(8'h01), ph(0));
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      r = i[3];
      cmd(3'h4, r, 8'h00, {5'h00, i[2:0]}, i[2] ? 2'h3 : 2'h2);
      if (!i[2]) st[r] = 8'h01 << i[1:0];
      chk(dec(st[r]), ph(r));
      cmd(3'h7, r, 8'h32, 8'h00, 2'h2);
      chk(st[r], ack_rdata_ff);
    end
    $display("state test done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      r = seed[0];
      cmd(3'h4, r, 8'h00, 8'h02, 2'h2);
      st[r] = 8'h04;
      d = i[0] ? vid[r] : seed[15:8];
      cmd(i[1] ? 3'h1 : 3'h2, r, 8'h00, d, 2'h2);
      if (d !== vid[r]) st[r] = 8'h01;
      vid[r] = d;
      chk(vid[r], r ? b_vid_code : a_vid_code);
      chk(dec(st[r]), ph(r));
      #3300;
    end
    $display("voltage test done");
    cmd(3'h5, 0, 8'h34, 8'h02, 2'h2);
    cmd(3'h4, 0, 8'h00, 8'h01, 2'h3);
    cmd(3'h1, 0, 8'h00, ~vid[0], 2'h3);
    chk(vid[0], a_vid_code);
    chk(dec(st[0]), ph(0));
    cmd(3'h4, 1, 8'h00, 8'h01, 2'h2);
    st[1] = 8'h02;
    chk(dec(st[1]), ph(1));
    cmd(3'h7, 0, 8'h34, 8'h00, 2'h2);
    chk(8'h02, ack_rdata_ff);
    cmd(3'h5, 0, 8'h34, 8'h00, 2'h2);
    cmd(3'h4, 0, 8'h00, 8'h01, 2'h2);
    st[0] = 8'h02;
    chk(dec(st[0]), ph(0));
    $display("lock test done");
    cmd(3'h2, 0, 8'h00, ~vid[0], 2'h2);
    vid[0] = ~vid[0];
    st[0] = 8'h01;
    chk(dec(st[0]), ph(0));
    cmd(3'h1, 0, 8'h00, vid[0] + 8'h01, 2'h2);
    vid[0] = vid[0] + 8'h01;
    cmd(3'h7, 0, 8'h31, 8'h00, 2'h2);
    chk(vid[0], ack_rdata_ff);
    cmd(3'h5, 1, 8'h32, 8'h01, 2'h3);
    chk(dec(st[1]), ph(1));
    cmd(3'h0, 1, 8'h00, 8'h00, 2'h3);
    cmd(3'h7, 1, 8'h34, 8'h00, 2'h2);
    chk(8'h00, ack_rdata_ff);
    $display("corner test done");
    end_sim;
  end
endmodule // power_state_phase_control_test
